// >>> hw/ucfp_policy.v
// Undercurrent fault policy: config byte, alert, output enable control
`timescale 1ns/1ns
`include "ucfp_consts.vh"

// Operation
// (R1) Byte command 0xE6 reads and writes the undercurrent fault policy.
// (R2) Any detected fault pulls the alert line low and sets status bit.
// (R3) Response 00 keeps the output regulating despite the fault.
// (R4) Response 01 runs for the delay, then applies retry setting if fault remains.
// (R5) Response 10 disables output immediately, then follows the retry count.
// (R6) Response 11 holds output off while fault lasts, re-enables when gone.
// (R7) Retry count 000 makes no restart; output stays off until fault cleared.
// (R8) Codes 001 to 110 give one to six restarts, then stay off.
// (R9) Code 111 retries forever until commanded off, power lost, other fault.
// (R10) Restart attempts are spaced by delay field times 8.2 ms.
// (R11) Continue-then-act delay is delay field times 10 ms.
// (R12) Delay field zero adds no wait before acting or restarting.
module ucfp_policy (
    clk,
    reset_n,
    cmd_code,
    cmd_write,
    cmd_wdata,
    cmd_read,
    cmd_rdata,
    cmd_hit,
    uc_fault_raw,
    output_commanded_on,
    other_fault_shutdown,
    status_clear,
    fault_alert_line_n,
    uc_status_bit,
    output_enable,
    policy_state
);
    input wire clk;
    input wire reset_n;
    input wire [7:0] cmd_code;
    input wire cmd_write;
    input wire [7:0] cmd_wdata;
    input wire cmd_read;
    output reg [7:0] cmd_rdata;
    output wire cmd_hit;
    input wire uc_fault_raw;
    input wire output_commanded_on;
    input wire other_fault_shutdown;
    input wire status_clear;
    output wire fault_alert_line_n;
    output reg uc_status_bit;
    output reg output_enable;
    output reg [2:0] policy_state;

    // Response states, also shown on policy_state:
    // run follows the on command and waits for a fault edge;
    // continue keeps the output on while the operate delay runs;
    // retry wait holds the output off for the restart spacing;
    // attempt turns the output on for one cycle as a restart;
    // hold off waits for the fault to go, latched for fault gone and status clear
    localparam ST_RUN = 3'd0;
    localparam ST_CONTINUE = 3'd1;
    localparam ST_RETRY_WAIT = 3'd2;
    localparam ST_ATTEMPT = 3'd3;
    localparam ST_HOLD_OFF = 3'd4;
    localparam ST_LATCHED = 3'd5;

    // Unit lengths in clock cycles; both fit the timer's 20-bit tick counter
    localparam integer OPERATE_CYC_INT = `UCFP_OPERATE_UNIT_CYC;
    localparam integer RESTART_CYC_INT = `UCFP_RESTART_UNIT_CYC;
    localparam [19:0] OPERATE_CYC = OPERATE_CYC_INT[19:0];
    localparam [19:0] RESTART_CYC = RESTART_CYC_INT[19:0];

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers, fault comes straight off an analog comparator
    // Two stages: only the second is read, the first may be metastable
    // Status clear and command strobes come from logic on this clock, no sync
    reg [1:0] fault_sync_reg;
    reg [1:0] cmd_on_sync_reg;
    reg [1:0] other_sync_reg;
    wire fault_now;
    wire cmd_on;
    wire other_off;

    always @(posedge clk) begin
        if (!reset_n) begin
            fault_sync_reg <= 2'b00;
            cmd_on_sync_reg <= 2'b00;
            other_sync_reg <= 2'b00;
        end else begin
            fault_sync_reg <= {fault_sync_reg[0], uc_fault_raw};
            cmd_on_sync_reg <= {cmd_on_sync_reg[0], output_commanded_on};
            other_sync_reg <= {other_sync_reg[0], other_fault_shutdown};
        end
    end

    assign fault_now = fault_sync_reg[1];
    assign cmd_on = cmd_on_sync_reg[1];
    assign other_off = other_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // Policy byte register
    // Reset value is ignore, no retries, no delay
    reg [7:0] policy_reg;
    wire [1:0] resp;
    wire [2:0] retry_set;
    wire [2:0] delay_units;

    // Hit is decoded live from the code, so it qualifies both strobes
    assign cmd_hit = (cmd_code == `UCFP_CMD_POLICY);

    always @(posedge clk) begin
        if (!reset_n) begin
            policy_reg <= `UCFP_POLICY_RESET;
        end else if (cmd_write && cmd_hit) begin
            policy_reg <= cmd_wdata; // [R1]
        end
    end

    // Read data is registered; other codes read zero
    // Zero rather than stale data, so a misaddressed read is easy to spot
    always @(posedge clk) begin
        if (!reset_n) begin
            cmd_rdata <= 8'h00;
        end else if (cmd_read) begin
            cmd_rdata <= cmd_hit ? policy_reg : 8'h00; // [R1]
        end
    end

    // Field split of the policy byte
    assign resp = policy_reg[`UCFP_RESP_MSB:`UCFP_RESP_LSB];
    assign retry_set = policy_reg[`UCFP_RETRY_MSB:`UCFP_RETRY_LSB];
    assign delay_units = policy_reg[`UCFP_DELAY_MSB:`UCFP_DELAY_LSB];

    ////////////////////////////////////////////////////////////////////////
    // Sticky status bit; a new fault edge wins over a clear
    // Set wins so a clear in the same cycle cannot hide a fresh fault
    reg fault_prev_reg;
    wire fault_rise;

    // Edge detect on the synchronised level; prev resets to the idle level 0
    assign fault_rise = fault_now && !fault_prev_reg;

    always @(posedge clk) begin
        if (!reset_n) begin
            fault_prev_reg <= 1'b0;
            uc_status_bit <= 1'b0;
        end else begin
            fault_prev_reg <= fault_now;
            if (fault_rise) begin
                uc_status_bit <= 1'b1; // [R2]
            end else if (status_clear) begin
                uc_status_bit <= 1'b0;
            end
        end
    end

    // Alert is low while the status bit stands, in every response mode
    assign fault_alert_line_n = ~uc_status_bit; // [R2]

    ////////////////////////////////////////////////////////////////////////
    // Shared delay timer, unit length picked by the waiting state
    reg timer_start;
    reg [19:0] timer_unit;
    wire timer_done;

    // The delay field is sampled when the timer starts: rewriting it mid-wait
    // leaves the remaining wait unchanged, a limitation the host must keep in mind
    ucfp_unit_timer u_timer (
        .clk(clk),
        .reset_n(reset_n),
        .start(timer_start),
        .units(delay_units),
        .unit_cycles(timer_unit),
        .done(timer_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Response state machine
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [2:0] tries_reg;
    reg [2:0] tries_next;
    reg timer_armed_reg;
    reg timer_armed_next;
    wire retries_left;

    // Code 111 never runs out; others compare against the used count
    assign retries_left = (retry_set == `UCFP_RETRY_ENDLESS) ||
        (tries_reg < retry_set); // [R8] [R9]

    always @* begin
        state_next = state_reg;
        tries_next = tries_reg;
        timer_armed_next = timer_armed_reg;
        timer_start = 1'b0;
        timer_unit = RESTART_CYC;
        case (state_reg)
            ST_RUN: begin
                // Every new fault starts with a fresh retry budget
                tries_next = 3'h0;
                if (fault_rise) begin
                    case (resp)
                        `UCFP_RESP_IGNORE: state_next = ST_RUN; // [R3]
                        `UCFP_RESP_CONTINUE: begin
                            state_next = ST_CONTINUE; // [R4]
                            timer_start = 1'b1;
                        end
                        `UCFP_RESP_DISABLE_RETRY: begin
                            state_next = ST_RETRY_WAIT; // [R5]
                            timer_armed_next = 1'b0;
                        end
                        default: state_next = ST_HOLD_OFF; // [R6]
                    endcase
                end
            end
            ST_CONTINUE: begin
                timer_unit = OPERATE_CYC; // [R11]
                // Fault gone before the delay ends: carry on as if nothing happened
                if (!fault_now) begin
                    state_next = ST_RUN;
                end else if (timer_done) begin
                    // Fault outlived the delay: shut down and use retries [R4]
                    state_next = ST_RETRY_WAIT;
                    timer_armed_next = 1'b0;
                end
            end
            ST_RETRY_WAIT: begin
                timer_unit = RESTART_CYC; // [R10]
                // Arm the timer once per wait, then wait for it to expire
                if (!retries_left) begin
                    state_next = ST_LATCHED; // [R7] [R8]
                end else if (!timer_armed_reg) begin
                    timer_start = 1'b1;
                    timer_armed_next = 1'b1;
                end else if (timer_done) begin
                    state_next = ST_ATTEMPT; // [R10] [R12]
                    timer_armed_next = 1'b0;
                    if (retry_set != `UCFP_RETRY_ENDLESS) begin
                        tries_next = tries_reg + 3'h1;
                    end
                end
            end
            ST_ATTEMPT: begin
                // One cycle with output on; a live fault counts as failed restart
                if (fault_now) begin
                    state_next = ST_RETRY_WAIT;
                end else begin
                    state_next = ST_RUN;
                end
            end
            ST_HOLD_OFF: begin
                // No retry budget here; fault gone, command off or another shutdown ends it
                if (!fault_now) begin
                    state_next = ST_RUN; // [R6]
                end
            end
            ST_LATCHED: begin
                // Stays off until the fault is gone and its status cleared
                if (!fault_now && !uc_status_bit) begin
                    state_next = ST_RUN; // [R7] [R8]
                end
            end
            // Unused codes fall back to run
            default: state_next = ST_RUN;
        endcase
        // Output commanded off or another shutdown ends any retry loop
        // The retry budget is cleared too, so a later fault starts afresh
        if ((!cmd_on || other_off) && state_reg != ST_RUN) begin
            state_next = ST_RUN; // [R9]
            tries_next = 3'h0;
        end
    end

    // State, retry count and timer arm flag
    always @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= ST_RUN;
            tries_reg <= 3'h0;
            timer_armed_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            tries_reg <= tries_next;
            timer_armed_reg <= timer_armed_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs: enable follows state and external command
    // Reset leaves the output off until the synchronised on command arrives
    // An attempt still obeys the on command and other shutdowns
    always @(posedge clk) begin
        if (!reset_n) begin
            output_enable <= 1'b0;
            policy_state <= ST_RUN;
        end else begin
            policy_state <= state_next;
            case (state_next)
                ST_RUN: output_enable <= cmd_on && !other_off; // [R3]
                ST_CONTINUE: output_enable <= cmd_on && !other_off; // [R4]
                ST_ATTEMPT: output_enable <= cmd_on && !other_off;
                default: output_enable <= 1'b0; // [R5] [R6] [R7]
            endcase
        end
    end
endmodule // ucfp_policy

// >>> hw/ucfp_consts.vh
// Constants for the undercurrent fault policy block
`ifndef UCFP_CONSTS_VH
`define UCFP_CONSTS_VH
`define UCFP_CMD_POLICY 8'he6
`define UCFP_POLICY_RESET 8'h00
`define UCFP_RESP_MSB 7
`define UCFP_RESP_LSB 6
`define UCFP_RETRY_MSB 5
`define UCFP_RETRY_LSB 3
`define UCFP_DELAY_MSB 2
`define UCFP_DELAY_LSB 0
`define UCFP_RESP_IGNORE 2'b00
`define UCFP_RESP_CONTINUE 2'b01
`define UCFP_RESP_DISABLE_RETRY 2'b10
`define UCFP_RESP_DISABLE_CLEAR 2'b11
`define UCFP_RETRY_NONE 3'b000
`define UCFP_RETRY_ENDLESS 3'b111
`define UCFP_CLK_HZ 10000000
`define UCFP_OPERATE_UNIT_US 10000
`define UCFP_RESTART_UNIT_US 8200
`define UCFP_OPERATE_UNIT_CYC ((`UCFP_CLK_HZ / 1000000) * `UCFP_OPERATE_UNIT_US)
`define UCFP_RESTART_UNIT_CYC ((`UCFP_CLK_HZ / 1000000) * `UCFP_RESTART_UNIT_US)
`endif

// >>> hw/ucfp_unit_timer.v
// Delay timer counting whole units of a programmable length
`timescale 1ns/1ns
module ucfp_unit_timer (
    clk,
    reset_n,
    start,
    units,
    unit_cycles,
    done
);
    input wire clk;
    input wire reset_n;
    input wire start;
    input wire [2:0] units;
    input wire [19:0] unit_cycles;
    output reg done;

    reg [19:0] tick_reg;
    reg [2:0] left_reg;
    reg run_reg;

    // Zero units ends on the next edge, so a zero delay adds no wait
    always @(posedge clk) begin
        if (!reset_n) begin
            tick_reg <= 20'h00000;
            left_reg <= 3'h0;
            run_reg <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                tick_reg <= 20'h00000;
                left_reg <= units;
                run_reg <= 1'b1;
            end else if (run_reg) begin
                if (left_reg == 3'h0) begin
                    run_reg <= 1'b0;
                    done <= 1'b1;
                end else if (tick_reg == unit_cycles - 20'h00001) begin
                    tick_reg <= 20'h00000;
                    left_reg <= left_reg - 3'h1;
                end else begin
                    tick_reg <= tick_reg + 20'h00001;
                end
            end
        end
    end
endmodule // ucfp_unit_timer

// >>> tb/ucfp_policy_chk.sv
// Port checker for the undercurrent fault policy block
`timescale 1ns/1ns
module ucfp_policy_chk (
    input wire clk,
    input wire reset_n,
    input wire cmd_write,
    input wire [7:0] cmd_wdata,
    input wire cmd_read,
    input wire [7:0] cmd_rdata,
    input wire cmd_hit,
    input wire uc_fault_raw,
    input wire output_commanded_on,
    input wire other_fault_shutdown,
    input wire fault_alert_line_n,
    input wire uc_status_bit,
    input wire output_enable,
    input wire [2:0] policy_state
);
    reg [7:0] pol_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////
    // Shadow of the policy byte, since the active mode is not a port
    always @(posedge clk) begin
        if (!reset_n) pol_reg <= 8'h00;
        else if (cmd_write && cmd_hit) pol_reg <= cmd_wdata;
    end
    ////////////////////////////////////////////////////////////
    // Command bus, alert and output control relations
    property p_rd_other; cmd_read && !cmd_hit |=> cmd_rdata == 8'h00; endproperty
    a_rd_other: assert property (p_rd_other) else $error("foreign read not zero");
    property p_rd_back; cmd_write && cmd_hit ##1 cmd_read && cmd_hit && !cmd_write
        |=> cmd_rdata == $past(cmd_wdata, 2); endproperty
    a_rd_back: assert property (p_rd_back) else $error("read back differs");
    property p_alert; fault_alert_line_n == !uc_status_bit; endproperty
    a_alert: assert property (p_alert) else $error("alert differs from status");
    property p_status; $rose(uc_fault_raw) |-> ##[1:4] uc_status_bit; endproperty
    a_status: assert property (p_status) else $error("status not set");
    property p_ignore; pol_reg[7:6] == 2'h0 && output_enable && output_commanded_on
        && !other_fault_shutdown |=> output_enable; endproperty
    a_ignore: assert property (p_ignore) else $error("output dropped when ignoring");
    property p_hold; (pol_reg[7:6] == 2'h3 && uc_fault_raw)[*6] |-> !output_enable; endproperty
    a_hold: assert property (p_hold) else $error("output on during fault");
    property p_latched; policy_state == 3'h5 && uc_status_bit |-> !output_enable; endproperty
    a_latched: assert property (p_latched) else $error("output on after retries");
    property p_no_wait; policy_state == 3'h2 && pol_reg[2:0] == 3'h0
        |-> ##[1:4] policy_state != 3'h2; endproperty
    a_no_wait: assert property (p_no_wait) else $error("zero delay still waits");
endmodule // ucfp_policy_chk

bind ucfp_policy ucfp_policy_chk ucfp_policy_chk_i (.clk, .reset_n, .cmd_write, .cmd_wdata,
    .cmd_read, .cmd_rdata, .cmd_hit, .uc_fault_raw, .output_commanded_on,
    .other_fault_shutdown, .fault_alert_line_n, .uc_status_bit, .output_enable, .policy_state);

// >>> tb/ucfp_host_model.sv
// Host controller model issuing byte transfers on the command bus
`timescale 1ns/1ns
module ucfp_host_model (
    input wire clk,
    output reg [7:0] cmd_code,
    output reg cmd_write,
    output reg [7:0] cmd_wdata,
    output reg cmd_read
);
    initial {cmd_write, cmd_read, cmd_code, cmd_wdata} = 18'h00000;
    // One transfer slot; idle lines flip so a stale byte is never taken for data
    task op(input reg w, input reg r, input reg [7:0] code, input reg [7:0] data);
        @(posedge clk);
        #1;
        cmd_write = w;
        cmd_read = r;
        cmd_code = (w || r) ? code : ~cmd_code;
        cmd_wdata = w ? data : ~cmd_wdata;
    endtask
endmodule // ucfp_host_model

// >>> tb/tb_undercurrent_fault_response.sv
// Self-checking testbench for the undercurrent fault policy block
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value at %0t: got %h want %h", $time, (g), (e)); end end
module tb_undercurrent_fault_response;
    reg clk = 1'b0;
    reg reset_n = 1'b0;
    reg fault = 1'b0;
    reg cmd_on = 1'b0;
    reg other_off = 1'b0;
    reg st_clr = 1'b0;
    reg rd_q = 1'b0;
    reg prev;
    reg [7:0] v, exp_v;
    reg [2:0] exp_st;
    reg [7:0] exp_q[$];
    wire [7:0] code, wdata, rdata;
    wire wr, rd, hit, alert_n, st, oe;
    wire [2:0] state;
    integer n_errors = 0;
    integer num_checks = 0;
    integer seed = 32'h0c9a;
    integer i, n, k;
    always #50 clk = ~clk;
    ucfp_policy ucfp_policy_i (.clk(clk), .reset_n(reset_n), .cmd_code(code),
        .cmd_write(wr), .cmd_wdata(wdata), .cmd_read(rd), .cmd_rdata(rdata), .cmd_hit(hit),
        .uc_fault_raw(fault), .output_commanded_on(cmd_on), .other_fault_shutdown(other_off),
        .status_clear(st_clr), .fault_alert_line_n(alert_n), .uc_status_bit(st),
        .output_enable(oe), .policy_state(state));
    ucfp_host_model ucfp_host_model_i (.clk(clk), .cmd_code(code), .cmd_write(wr),
        .cmd_wdata(wdata), .cmd_read(rd));
    ////////////////////////////////////////////////////////////
    // Read answers land one edge after the strobe; compare with the oldest note
    always @(posedge clk) begin
        if (rd_q) begin
            exp_v = exp_q.pop_front();
            `CHK(rdata, exp_v)
        end
        rd_q <= rd;
    end
    task finish_test;
        if (n_errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task cyc(input integer c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task wrt(input [7:0] c, input [7:0] d);
        ucfp_host_model_i.op(1'b1, 1'b0, c, d);
    endtask
    task rd_chk(input [7:0] c, input [7:0] e);
        exp_q.push_back(e);
        ucfp_host_model_i.op(1'b0, 1'b1, c, 8'h00);
    endtask
    task idle;
        ucfp_host_model_i.op(1'b0, 1'b0, 8'h00, 8'h00);
    endtask
    // Bounded wait on the output enable; running out counts as a mismatch
    task wait_oe(input reg val);
        for (k = 0; oe !== val; k++) begin
            if (k == 30) begin
                n_errors++;
                finish_test;
            end
            cyc(1);
        end
    endtask
    // Restart attempts show as rising edges of the output enable
    task count_rises(input integer len);
        n = 0;
        repeat (len) begin
            prev = oe;
            cyc(1);
            if (oe === 1'b1 && prev === 1'b0) n++;
        end
    endtask
    // Fault under one policy; exp below zero stands for endless retries
    task run_fault(input [7:0] cfg, input integer exp);
        wrt(8'he6, cfg);
        idle;
        fault = 1'b1;
        cyc(4);
        `CHK({st, alert_n}, 2'h2)
        count_rises(150);
        if (exp < 0) begin
            `CHK(n > 20, 1'b1)
            other_off = 1'b1;
            wait_oe(1'b0);
            count_rises(20);
            `CHK(n, 0)
            `CHK(state, 3'h0)
            other_off = 1'b0;
        end else begin
            `CHK(n, exp)
            `CHK(oe, cfg[7:6] == 2'h0)
            exp_st = (cfg[7:6] == 2'h3) ? 3'h4 : 3'h5;
            `CHK(state, (cfg[7:6] == 2'h0) ? 3'h0 : exp_st)
        end
        fault = 1'b0;
        cyc(4);
        st_clr = 1'b1;
        cyc(1);
        st_clr = 1'b0;
        wait_oe(1'b1);
    endtask
    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        #1;
        reset_n = 1'b1;
        cmd_on = 1'b1;
        wait_oe(1'b1);
        `CHK({st, alert_n}, 2'h1)
        rd_chk(8'he6, 8'h00);
        for (i = 0; i < 8; i++) begin
            v = $random(seed);
            wrt(8'he6, v);
            `CHK(hit, 1'b1)
            rd_chk(8'he6, v);
            wrt(v | 8'h01, ~v);
            `CHK(hit, 1'b0)
            rd_chk(v | 8'h01, 8'h00);
            rd_chk(8'he6, v);
        end
        idle;
        for (i = 0; i < 7; i++) run_fault({2'h2, i[2:0], 3'h0}, i);
        run_fault(8'h00, 0);
        run_fault(8'hc0, 0);
        run_fault(8'h50, 2);
        run_fault(8'hb8, -1);
        // One restart unit of 8.2 ms is 82000 cycles from shutdown to attempt
        wrt(8'he6, 8'h89);
        idle;
        fault = 1'b1;
        wait_oe(1'b0);
        for (n = 0; oe !== 1'b1 && n < 82100; n++) cyc(1);
        `CHK(n >= 82000 && n <= 82010, 1'b1)
        fault = 1'b0;
        cyc(4);
        `CHK({state, oe}, 4'ha)
        st_clr = 1'b1;
        cyc(1);
        st_clr = 1'b0;
        wait_oe(1'b1);
        // Mid-run reset brings outputs and the policy byte back to reset values
        reset_n = 1'b0;
        cyc(2);
        reset_n = 1'b1;
        `CHK({oe, st, alert_n, state, rdata}, {3'h1, 3'h0, 8'h00})
        rd_chk(8'he6, 8'h00);
        idle;
        cyc(2);
        finish_test;
    end
endmodule // tb_undercurrent_fault_response
